// ===== hdl/dip_detect_pkg.sv
// Constants, types and helpers for the five-channel solenoid dip detector.
// Assumes a 50 MHz core clock and 12-bit drain-voltage sample codes.
//
// Operation
// R1 - After descent run, keep sampling and auto-zeroing
// R2 - No dip within window: set fault
// R3 - Dip found: enter post-dip, keep sampling
// R4 - Post-dip sampling runs to window end
// R5 - Three rising samples after dip: clear fault
// R6 - After verdict return idle, await activation
// R7 - One sample per period, compared to previous
// R8 - Three descending 3 mV samples end pre-dip
// R9 - Accept activation only if grounded through settle
// R10 - Faults 4,3,2,1,5 on bits 15..11
// R11 - Each channel has own machine, timer, fault
package dip_detect_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int CH_NUM = 5;       // Monitored channels
  localparam int SAMPLE_W = 12;    // Sample code width
  localparam int CNT_W = 22;       // Elapsed-time counter width
  localparam int RUN_W = 2;        // Run counter width
  localparam int WORD_W = 16;      // Fault word width

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;          // 50 MHz
  localparam int SAMPLE_PERIOD_US = 72;       // Sample period
  localparam int SETTLE_TIME_US = 400;        // Least settle time
  localparam int WINDOW_TIME_MS = 56;         // Monitoring window
  localparam int SAMPLE_CYC =
    (SAMPLE_PERIOD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC_DEF =
    (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINDOW_CYC_DEF =
    (WINDOW_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] SAMPLE_LAST = 12'(SAMPLE_CYC - 1);

  // ---------------------------------------------------------------
  // Thresholds in sample codes (0.25 mV per code)
  // ---------------------------------------------------------------
  localparam logic [11:0] RISE_MIN = 12'h002;   // 0.5 mV
  localparam logic [11:0] DESC_MIN = 12'h00c;   // 3 mV
  localparam logic [11:0] GND_MAX = 12'h028;    // Near-ground limit
  localparam logic [11:0] HIGH_MIN = 12'h800;   // Driver-off level
  localparam logic [1:0] DESC_RUN_LAST = 2'h2;  // Third descent
  localparam logic [1:0] POST_RUN_LAST = 2'h2;  // Third rise

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] FAULT_WORD_RST = 16'h0000;
  localparam logic [11:0] SAMPLE_RST = 12'h000;

  // Channel detector states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SETTLE = 5'b00010,
    ST_PRE    = 5'b00100,
    ST_DIP    = 5'b01000,
    ST_POST   = 5'b10000
  } det_state_t;

  // True when a exceeds b by at least d
  function automatic logic is_above(input logic [11:0] a,
                                    input logic [11:0] b,
                                    input logic [11:0] d);
    is_above = ({1'b0, a} >= ({1'b0, b} + {1'b0, d}));
  endfunction : is_above

  // Fault word bit of a channel: ch 0..3 to 12..15, ch 4 to 11
  function automatic int fault_pos(input int ch);
    fault_pos = (ch < 4) ? (12 + ch) : 11;
  endfunction : fault_pos

endpackage : dip_detect_pkg

// ===== hdl/sample_tick_gen.sv
// Sample period divider: one-cycle tick every sample period.
// Assumes the single core clock and its asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module sample_tick_gen
  import dip_detect_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  output logic tick_o
);

  logic [11:0] div_r;   // Cycle count inside the period
  logic tick_r;         // Registered tick

  // -------------------------------------------------------------
  // Divider
  // -------------------------------------------------------------
  // Wraps at the period end and flags the wrap
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_r <= 12'h000;
      tick_r <= 1'b0;
    end else begin
      div_r <= (div_r == SAMPLE_LAST) ? 12'h000 : div_r + 12'h001;
      tick_r <= (div_r == SAMPLE_LAST);  // see R7
    end
  end

  assign tick_o = tick_r;

endmodule : sample_tick_gen
`default_nettype wire

// ===== hdl/dip_detector.sv
// Five-channel solenoid waveform checker: activation, pre-dip, dip and
// post-dip tracking, with one fault bit per channel in a fault word.
// Assumes sample codes synchronous to core_clk_i; the serial read-out
// of the fault word lives outside this block.
`timescale 1ns/10ps
`default_nettype none
module dip_detector
  import dip_detect_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC_DEF,  // Activation settle
  parameter int WINDOW_CYCLES = WINDOW_CYC_DEF   // Monitoring window
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [CH_NUM-1:0][SAMPLE_W-1:0] solenoid_voltage_inputs_i,
  output logic [WORD_W-1:0] fault_word_o,
  output logic [CH_NUM-1:0] active_o,
  output logic [CH_NUM-1:0] pass_o,
  output logic [CH_NUM-1:0] fail_o
);

  // ---------------------------------------------------------------
  // Shared timing
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
  localparam logic [CNT_W-1:0] WINDOW_LAST = CNT_W'(WINDOW_CYCLES - 1);

  logic tick;                          // Sample strobe
  logic [WORD_W-1:0] fault_word_r;     // Fault storage, mapped
  logic [WORD_W-1:0] fault_word_nxt;   // Next fault word
  logic [CH_NUM-1:0] fault_nxt;        // Per-channel next fault
  logic [CH_NUM-1:0] active_nxt;       // Channel not idle next
  logic [CH_NUM-1:0] pass_nxt;         // Pass verdict this cycle
  logic [CH_NUM-1:0] fail_nxt;         // Fail verdict this cycle
  logic [CH_NUM-1:0] active_r;
  logic [CH_NUM-1:0] pass_r;
  logic [CH_NUM-1:0] fail_r;

  // Sample period divider
  sample_tick_gen u_tick (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .tick_o(tick)
  );

  // ---------------------------------------------------------------
  // Per-channel detectors
  // ---------------------------------------------------------------
  for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
    det_state_t state_r;                 // Detector state
    det_state_t state_nxt;
    logic [SAMPLE_W-1:0] prev_r;         // Previous sample
    logic [SAMPLE_W-1:0] ref_r;          // Auto-zero reference
    logic [SAMPLE_W-1:0] ref_nxt;
    logic [RUN_W-1:0] run_r;             // Consecutive-slope run
    logic [RUN_W-1:0] run_nxt;
    logic [CNT_W-1:0] elapsed_r;         // Cycles since activation
    logic fault_now;                     // Stored fault of channel
    logic fault_c;
    logic pass_c;
    logic fail_c;

    wire [SAMPLE_W-1:0] smp = solenoid_voltage_inputs_i[c];
    wire near_gnd = (smp <= GND_MAX);                 // Driver on
    wire prev_high = (prev_r >= HIGH_MIN);            // Driver was off
    wire descend = is_above(prev_r, smp, DESC_MIN);   // 3 mV drop
    wire rise_ref = is_above(smp, ref_r, RISE_MIN);   // Above reference
    wire rise_prev = is_above(smp, prev_r, RISE_MIN); // Slope positive
    wire settle_done = (elapsed_r == SETTLE_LAST);
    wire win_end = (elapsed_r == WINDOW_LAST);

    assign fault_now = fault_word_r[fault_pos(c)];

    // Next-state and verdict decode
    always_comb begin
      state_nxt = state_r;
      ref_nxt = ref_r;
      run_nxt = run_r;
      fault_c = fault_now;
      pass_c = 1'b0;
      fail_c = 1'b0;
      case (state_r)
        ST_IDLE: begin
          // Falling swing from supply to ground starts the settle
          if (tick && prev_high && near_gnd) begin
            state_nxt = ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (!near_gnd) begin
            state_nxt = ST_IDLE;              // see R9
          end else if (settle_done) begin
            state_nxt = ST_PRE;               // see R9
            ref_nxt = smp;
            run_nxt = '0;
          end
        end
        ST_PRE: begin
          if (tick) begin
            if (descend) begin
              // Count descents, no auto-zero until the run is seen
              run_nxt = run_r + 2'h1;         // see R8
              if (run_r == DESC_RUN_LAST) begin
                state_nxt = ST_DIP;           // see R8
                ref_nxt = smp;
                run_nxt = '0;
              end
            end else begin
              run_nxt = '0;                   // see R8
              if (rise_ref) begin
                ref_nxt = smp;                // Auto-zero on rise
              end
            end
          end
          // Window end wins over a descent run seen at the same tick
          if (win_end) begin
            state_nxt = ST_IDLE;              // see R2
            fault_c = 1'b1;
            fail_c = 1'b1;
          end
        end
        ST_DIP: begin
          if (tick) begin
            ref_nxt = smp;                    // see R1
            if (rise_prev) begin
              state_nxt = ST_POST;            // see R3
              run_nxt = '0;
            end
          end
          // A dip at the last cycle leaves no room for post-dip rises
          if (win_end) begin
            state_nxt = ST_IDLE;              // see R2
            fault_c = 1'b1;
            fail_c = 1'b1;
          end
        end
        ST_POST: begin
          if (tick) begin
            if (rise_prev) begin
              run_nxt = run_r + 2'h1;
              if (run_r == POST_RUN_LAST) begin
                state_nxt = ST_IDLE;          // see R5, see R6
                fault_c = 1'b0;
                pass_c = 1'b1;
              end
            end else begin
              run_nxt = '0;                   // see R4
            end
          end
          if (win_end && !pass_c) begin
            state_nxt = ST_IDLE;              // see R4, see R6
            fault_c = 1'b1;
            fail_c = 1'b1;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end

    assign fault_nxt[c] = fault_c;
    assign pass_nxt[c] = pass_c;
    assign fail_nxt[c] = fail_c;
    assign active_nxt[c] = (state_nxt != ST_IDLE);

    // State and reference registers of this channel only
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        state_r <= ST_IDLE;
        ref_r <= SAMPLE_RST;
        run_r <= '0;
      end else begin
        state_r <= state_nxt;                 // see R11
        ref_r <= ref_nxt;
        run_r <= run_nxt;
      end
    end

    // Previous sample, taken once per period
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        prev_r <= SAMPLE_RST;
      end else if (tick) begin
        prev_r <= smp;                        // see R7
      end
    end

    // Elapsed time since the activation swing
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        elapsed_r <= '0;
      end else if (state_nxt == ST_IDLE || state_r == ST_IDLE) begin
        elapsed_r <= '0;
      end else begin
        elapsed_r <= elapsed_r + 22'h000001;  // see R2, see R11
      end
    end
  end

  // ---------------------------------------------------------------
  // Fault word mapping
  // ---------------------------------------------------------------
  // Solenoids 1..4 on bits 12..15, solenoid 5 on bit 11
  assign fault_word_nxt = {fault_nxt[3], fault_nxt[2], fault_nxt[1],
                           fault_nxt[0], fault_nxt[4], 11'h000}; // see R10

  // Output registers
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fault_word_r <= FAULT_WORD_RST;
      active_r <= '0;
      pass_r <= '0;
      fail_r <= '0;
    end else begin
      fault_word_r <= fault_word_nxt;
      active_r <= active_nxt;
      pass_r <= pass_nxt;
      fail_r <= fail_nxt;
    end
  end

  assign fault_word_o = fault_word_r;
  assign active_o = active_r;
  assign pass_o = pass_r;
  assign fail_o = fail_r;

endmodule : dip_detector
`default_nettype wire

// ===== testbench/dip_detector_properties.sv
// Port checker for the five-channel dip detector.
// Assumes one clock domain; bound into every dip_detector.
`timescale 1ns/10ps
`default_nettype none
module dip_detector_chk #(
  parameter int SETTLE_CYCLES = 20,
  parameter int WINDOW_CYCLES = 34000
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [4:0][11:0] solenoid_voltage_inputs_i,
  input wire logic [15:0] fault_word_o,
  input wire logic [4:0] active_o,
  input wire logic [4:0] pass_o,
  input wire logic [4:0] fail_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Fault bit of each channel, channel order
  wire [4:0] fbits = {fault_word_o[11], fault_word_o[15:12]};
  wire [4:0] verd = pass_o | fail_o;
  int act_cnt [5];  // Cycles each channel has been busy
  // Busy-time counters
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int c = 0; c < 5; c++) act_cnt[c] <= 0;
    end else begin
      for (int c = 0; c < 5; c++) begin
        act_cnt[c] <= active_o[c] ? act_cnt[c] + 1 : 0;
      end
    end
  end
  spare_bits_a: assert property (
    fault_word_o[10:0] == 11'h000) else $error("spare fault bits set");
  fail_sets_a: assert property (
    (fail_o & ~fbits) == 5'h00) else $error("fail without fault bit");
  pass_clears_a: assert property (
    (pass_o & fbits) == 5'h00) else $error("pass with fault bit");
  fault_hold_a: assert property (
    ((fbits ^ $past(fbits)) & ~verd) == 5'h00)
    else $error("fault bit moved without verdict");
  verdict_idle_a: assert property (
    verd != 5'h00 |-> ##2 (active_o & $past(verd, 2)) == 5'h00)
    else $error("channel busy after verdict");
  verdict_pulse_a: assert property (
    verd != 5'h00 |=> (verd & $past(verd)) == 5'h00)
    else $error("verdict pulse too long");
  verdict_excl_a: assert property (
    (pass_o & fail_o) == 5'h00) else $error("pass and fail together");
  verdict_active_a: assert property (
    (verd & ~$past(active_o)) == 5'h00)
    else $error("verdict from idle channel");
  for (genvar c = 0; c < 5; c++) begin : g_ch
    window_fail_a: assert property (
      fail_o[c] |-> act_cnt[c] >= WINDOW_CYCLES - 3 &&
      act_cnt[c] <= WINDOW_CYCLES + 1) else $error("fail off window end");
    window_bound_a: assert property (
      act_cnt[c] <= WINDOW_CYCLES + 1) else $error("channel past window");
  end
  cover property (pass_o != 5'h00);
  cover property (fail_o != 5'h00);
  cover property ((fbits & active_o) != 5'h00);
endmodule : dip_detector_chk
bind dip_detector dip_detector_chk #(.SETTLE_CYCLES(SETTLE_CYCLES),
  .WINDOW_CYCLES(WINDOW_CYCLES)) i_chk (.core_clk_i(core_clk_i),
  .resetn_i(resetn_i), .solenoid_voltage_inputs_i(solenoid_voltage_inputs_i),
  .fault_word_o(fault_word_o), .active_o(active_o), .pass_o(pass_o),
  .fail_o(fail_o));
`default_nettype wire

// ===== testbench/drain_wave_model.sv
// Drain-voltage source: one scripted sample code per sample period.
// Assumes 3600-cycle periods counted from reset release.
`timescale 1ns/10ps
`default_nettype none
module drain_wave_model (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic start_i,
  input wire logic [4:0][1:0] kind_i,
  input wire logic [4:0] drop_i,
  input wire logic [4:0] rise_i,
  output logic [4:0][11:0] sample_o
);
  int ph;  // Phase in the sample period
  int idx [5];  // Next script entry per channel
  logic [11:0] wave [5][$];  // Scripts: 0 quiet 1 pass 2 no dip 3 weak
  // Build one script with random step sizes
  function automatic void build(int c, int k);
    int d;
    int r;
    int v;
    d = int'(drop_i);  // Drop of 3 mV or more
    r = int'(rise_i);  // Rise of 0.5 mV or more
    v = 'h200;
    wave[c] = {12'h900, 12'h010, 12'h100, 12'h200};  // Swing low
    if (k == 0) wave[c] = {12'h010};
    else for (int i = 0; i < 13; i++) begin
      if (i < 3 || k == 2) v -= d;  // Descent run
      else if (i < ((k == 1) ? 7 : 6)) v += r;  // Dip then rises
      wave[c].push_back(12'(v));
    end
  endfunction : build
  // Change values mid-period so the sampling edge never races them
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ph <= 0;
      sample_o <= '0;
    end else begin
      ph <= (ph == 3599) ? 0 : ph + 1;
      if (start_i) for (int c = 0; c < 5; c++) begin
        build(c, int'(kind_i[c]));
        idx[c] = 0;
      end
      if (ph == 1800) for (int c = 0; c < 5; c++) begin
        if (idx[c] < wave[c].size()) begin
          sample_o[c] <= wave[c][idx[c]];
          idx[c]++;
        end
      end
    end
  end
endmodule : drain_wave_model
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the dip detector with a drain-wave model.
// Assumes shortened settle and window counts.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int SETTLE = 20;
  localparam int WINDOW = 34000;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic start = 1'b0;
  logic [4:0][1:0] kind = '0;
  logic [4:0] drop = 5'h0c;  // Random descent step, codes
  logic [4:0] rise = 5'h02;  // Random rise step, codes
  logic [4:0][11:0] smp;
  logic [15:0] fault_word;
  logic [4:0] active, pass, fail;
  int failures = 0;
  int checked = 0;
  int exp_fault [5];  // Model of each channel's fault bit
  initial forever #10 core_clk_i = ~core_clk_i;
  dip_detector #(.SETTLE_CYCLES(SETTLE), .WINDOW_CYCLES(WINDOW)) i_dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .solenoid_voltage_inputs_i(smp), .fault_word_o(fault_word),
    .active_o(active), .pass_o(pass), .fail_o(fail));
  drain_wave_model i_wave (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .start_i(start), .kind_i(kind), .drop_i(drop), .rise_i(rise),
    .sample_o(smp));
  // Compare and count
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Fault word from the model bits
  function automatic logic [15:0] exp_word();
    exp_word = '0;
    for (int c = 0; c < 5; c++) begin
      if (exp_fault[c] != 0) exp_word[(c < 4) ? 12 + c : 11] = 1'b1;
    end
  endfunction : exp_word
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // One activation round on all channels at once
  task automatic run_round(input logic [4:0][1:0] k);
    int want;
    int got;
    int seen;
    want = 0;
    got = 0;
    for (int c = 0; c < 5; c++) if (k[c] != 2'd0) want++;
    @(posedge core_clk_i);
    kind <= k;
    drop <= 5'(12 + $urandom % 20);
    rise <= 5'(2 + $urandom % 20);
    start <= 1'b1;
    @(posedge core_clk_i);
    start <= 1'b0;
    for (int n = 0; n < 60000 && got < want; n++) begin
      @(negedge core_clk_i);
      seen = 0;
      // Update every channel with a verdict before the word compare
      for (int c = 0; c < 5; c++) if ((pass[c] | fail[c]) === 1'b1) begin
        got++;
        seen++;
        exp_fault[c] = (k[c] != 2'd1);
        chk("quiet verdict", 16'h0, 16'(k[c] == 2'd0));
        chk("fail pulse", 16'(exp_fault[c]), {15'h0, fail[c]});
      end
      if (seen > 0) chk("fault word", exp_word(), fault_word);
    end
    if (got < want) begin
      failures++;
      $display("Error verdicts expected %0d seen %0d", want, got);
      stop_test();
    end
    repeat (8) @(negedge core_clk_i);
    chk("active", 16'h0, {11'h0, active});
    chk("fault word", exp_word(), fault_word);
    $display("Round done with %0d verdicts", got);
  endtask : run_round
  initial begin
    void'($urandom(32'hcb00));
    repeat (3) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    @(negedge core_clk_i);
    chk("reset word", 16'h0, fault_word);
    // Pass, no dip, weak rise, quiet, pass
    run_round({2'd1, 2'd0, 2'd3, 2'd2, 2'd1});
    // Rearmed channels 0, 2 and 4 flip their verdicts, channel 1 now passes; quiet channel 3 now fails on a weak rise
    run_round({2'd2, 2'd3, 2'd1, 2'd1, 2'd2});
    stop_test();
  end
endmodule : testbench
`default_nettype wire
